// ==== core/crc_params.svh ====
// offsets, field positions, reset values and timing counts of the crc unit
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// register byte addresses
`define CRC_CTRL_OFS 8'h00
`define CRC_SEED_OFS 8'h04
`define CRC_SUM_OFS 8'h08
`define CRC_DATA32_OFS 8'h0C
`define CRC_DATA16_OFS 8'h10
`define CRC_DATA8_OFS 8'h14
`define CRC_STAT_OFS 8'h18

// control field positions
`define CRC_POLY_LSB 0
`define CRC_POLY_MSB 1
`define CRC_DCMPL_BIT 2
`define CRC_DBYTE_BIT 3
`define CRC_DBIT_BIT 4
`define CRC_SCMPL_BIT 5
`define CRC_SBYTE_BIT 6
`define CRC_SBIT_BIT 7

// status field positions
`define CRC_BUSY_BIT 0
`define CRC_OVF_BIT 1

// generator polynomials
`define CRC_POLY_8005 32'h0000_8005
`define CRC_POLY_1021 32'h0000_1021
`define CRC_POLY_32 32'h04C1_1DB7

// reset values
`define CRC_CTRL_RST 8'h00
`define CRC_SEED_RST 32'h0000_0000

// update cycles per written width
`define CRC_BYTE_CYCLES 1
`define CRC_WORD_CYCLES 4

`endif

// ==== core/crc_pkg.sv ====
// types shared by the crc unit files
`default_nettype none
package crc_pkg;
	typedef enum logic [1:0] {
		POLY_CRC16 = 2'h0,
		POLY_CCITT = 2'h1,
		POLY_CRC32 = 2'h2
	} poly_sel_t;
	// encoding is byte count minus one
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h3
	} size_t;
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} state_t;
endpackage
`default_nettype wire

// ==== core/crc_buffer.sv ====
// two-entry buffer with valid and ready on both sides
`default_nettype none
module crc_buffer #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic [PW:0] count_next;
	logic not_full_reg;
	logic push;
	logic pop;

	// handshakes on both sides
	assign push = in_valid && not_full_reg;
	assign pop = out_valid && out_ready;
	assign in_ready = not_full_reg;
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];

	// occupancy after this cycle
	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	// pointers, count and registered ready
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			not_full_reg <= 1'b1;
		end else begin
			count_reg <= count_next;
			not_full_reg <= (count_next != (PW+1)'(DEPTH));
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0
					: wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0
					: rd_ptr_reg + 1'b1;
			end
		end
	end

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end
endmodule
`default_nettype wire

// ==== core/crc_step.sv ====
// one byte of crc update, most significant bit first
`default_nettype none
`include "crc_params.svh"
module crc_step (
	input wire logic [31:0] crc_in,
	input wire logic [7:0] data_byte,
	input wire crc_pkg::poly_sel_t poly_sel,
	output logic [31:0] crc_out
);
	import crc_pkg::*;
	logic [31:0] poly;
	logic [31:0] mask;
	logic wide;

	// polynomial and width for the selected mode
	always_comb begin
		wide = (poly_sel == POLY_CRC32);
		if (poly_sel == POLY_CRC32) begin
			poly = `CRC_POLY_32;
		end else if (poly_sel == POLY_CCITT) begin
			poly = `CRC_POLY_1021;
		end else begin
			poly = `CRC_POLY_8005;
		end
		mask = wide ? 32'hFFFF_FFFF : 32'h0000_FFFF;
	end

	// eight shifts of the linear feedback register
	always_comb begin
		logic [31:0] c;
		logic fb;
		c = crc_in & mask;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			fb = (wide ? c[31] : c[15]) ^ data_byte[i];
			c = ((c << 1) ^ (fb ? poly : 32'h0000_0000)) & mask;
		end
		crc_out = c;
	end
endmodule
`default_nettype wire

// ==== core/crc_unit.sv ====
// crc16 and crc32 calculation unit with register port and dma data port
// Operation
// - Polynomial select 0 runs the 16-bit 0x8005 generator.
// - Polynomial select 1 runs the 16-bit 0x1021 generator.
// - Polynomial select 2 runs the 32-bit 0x04C11DB7 generator.
// - Complement, byte reverse and bit reverse apply to data and sum.
// - Byte, half-word and word data fold exactly their width in.
// - A seed write loads the accumulator with any value.
// - A byte updates in one cycle and a word in four cycles.
// - The dma port feeds data words without processor help.
// - The sum reads as a 16-bit or 32-bit result by polynomial.
`default_nettype none
`include "crc_params.svh"
module crc_unit (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic dma_valid,
	input wire logic [31:0] dma_data,
	input wire crc_pkg::size_t dma_size,
	output logic dma_ready
);
	import crc_pkg::*;

	localparam int ENTRY_W = 34;

	logic [7:0] ctrl_reg;
	logic [31:0] crc_reg;
	logic [31:0] crc_next;
	logic [23:0] shift_reg;
	logic [1:0] remain_reg;
	state_t state_reg;
	logic ovf_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	poly_sel_t poly_sel;
	logic reg_data_wr;
	size_t reg_size;
	logic dma_take;
	logic buf_in_valid;
	logic buf_in_ready;
	logic [ENTRY_W-1:0] buf_in_data;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [ENTRY_W-1:0] buf_out_data;
	logic [31:0] raw_data;
	size_t raw_size;
	logic [31:0] xform_data;
	logic take;
	logic active;
	logic [7:0] step_byte;
	logic [31:0] step_out;
	logic seed_wr;
	logic [31:0] sum_view;
	logic ovf_set;

	assign poly_sel = poly_sel_t'(ctrl_reg[`CRC_POLY_MSB:`CRC_POLY_LSB]);
	assign seed_wr = wr && (addr == `CRC_SEED_OFS);

	// data writes by width
	always_comb begin
		reg_data_wr = 1'b0;
		reg_size = SZ_WORD;
		if (wr && addr == `CRC_DATA32_OFS) begin
			reg_data_wr = 1'b1;
			reg_size = SZ_WORD;
		end else if (wr && addr == `CRC_DATA16_OFS) begin
			reg_data_wr = 1'b1;
			reg_size = SZ_HALF;
		end else if (wr && addr == `CRC_DATA8_OFS) begin
			reg_data_wr = 1'b1;
			reg_size = SZ_BYTE;
		end
	end

	// dma wins the buffer; a colliding register write is dropped
	assign dma_take = dma_valid && buf_in_ready;
	assign buf_in_valid = dma_take || reg_data_wr;
	assign raw_data = dma_take ? dma_data : wdata;
	assign raw_size = dma_take ? dma_size : reg_size;
	assign ovf_set = reg_data_wr && (dma_take || !buf_in_ready);

	// data transforms, masked to the written width
	always_comb begin
		logic [31:0] d;
		logic [31:0] m;
		d = raw_data;
		m = 32'hFFFF_FFFF;
		if (raw_size == SZ_BYTE) begin
			m = 32'h0000_00FF;
		end else if (raw_size == SZ_HALF) begin
			m = 32'h0000_FFFF;
		end else begin
			m = 32'hFFFF_FFFF;
		end
		d = d & m;
		if (ctrl_reg[`CRC_DCMPL_BIT]) begin
			d = ~d & m;
		end
		if (ctrl_reg[`CRC_DBYTE_BIT]) begin
			if (raw_size == SZ_HALF) begin
				d = {16'h0000, d[7:0], d[15:8]};
			end else if (raw_size == SZ_WORD) begin
				d = {d[7:0], d[15:8], d[23:16], d[31:24]};
			end
		end
		if (ctrl_reg[`CRC_DBIT_BIT]) begin
			for (int b = 0; b < 4; b++) begin
				for (int i = 0; i < 8; i++) begin
					xform_data[8*b+i] = d[8*b+7-i];
				end
			end
		end else begin
			xform_data = d;
		end
	end

	assign buf_in_data = {raw_size, xform_data};

	// buffer between the writers and the engine
	crc_buffer #(
		.WIDTH(ENTRY_W),
		.DEPTH(2)
	) u_buffer (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	// the engine pulls a new entry only when no bytes remain
	assign buf_out_ready = (remain_reg == 2'h0);
	assign take = buf_out_valid && buf_out_ready;
	assign active = take || (remain_reg != 2'h0);
	// first byte straight from the buffer head
	assign step_byte = take ? buf_out_data[7:0] : shift_reg[7:0];

	crc_step u_step (
		.crc_in(crc_reg),
		.data_byte(step_byte),
		.poly_sel(poly_sel),
		.crc_out(step_out)
	);

	// accumulator: seed load, byte step or hold
	always_comb begin
		crc_next = crc_reg;
		if (seed_wr) begin
			crc_next = wdata;
		end else if (active) begin
			crc_next = step_out;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			crc_reg <= `CRC_SEED_RST;
		end else begin
			crc_reg <= crc_next;
		end
	end

	// byte sequencer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			remain_reg <= 2'h0;
			shift_reg <= 24'h00_0000;
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take) begin
						remain_reg <= buf_out_data[33:32];
						shift_reg <= buf_out_data[31:8];
						if (buf_out_data[33:32] != 2'h0) begin
							state_reg <= ST_RUN;
						end
					end
				end
				ST_RUN: begin
					remain_reg <= remain_reg - 2'h1;
					shift_reg <= {8'h00, shift_reg[23:8]};
					if (remain_reg == 2'h1) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// control register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= `CRC_CTRL_RST;
		end else if (wr && addr == `CRC_CTRL_OFS) begin
			ctrl_reg <= wdata[7:0];
		end
	end

	// sticky overflow, set wins over write-one-clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ovf_reg <= 1'b0;
		end else if (ovf_set) begin
			ovf_reg <= 1'b1;
		end else if (wr && addr == `CRC_STAT_OFS && wdata[`CRC_OVF_BIT]) begin
			ovf_reg <= 1'b0;
		end
	end

	// checksum transforms at the result width
	always_comb begin
		logic [31:0] s;
		logic w32;
		w32 = (poly_sel == POLY_CRC32);
		s = w32 ? crc_reg : {16'h0000, crc_reg[15:0]};
		if (ctrl_reg[`CRC_SCMPL_BIT]) begin
			s = w32 ? ~s : {16'h0000, ~s[15:0]};
		end
		if (ctrl_reg[`CRC_SBYTE_BIT]) begin
			s = w32 ? {s[7:0], s[15:8], s[23:16], s[31:24]}
				: {16'h0000, s[7:0], s[15:8]};
		end
		if (ctrl_reg[`CRC_SBIT_BIT]) begin
			for (int b = 0; b < 4; b++) begin
				for (int i = 0; i < 8; i++) begin
					sum_view[8*b+i] = s[8*b+7-i];
				end
			end
		end else begin
			sum_view = s;
		end
	end

	// read decode, zero outside the cycle after the strobe
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (rd) begin
			if (addr == `CRC_CTRL_OFS) begin
				rdata_next = {24'h00_0000, ctrl_reg};
			end else if (addr == `CRC_SEED_OFS) begin
				rdata_next = crc_reg;
			end else if (addr == `CRC_SUM_OFS) begin
				rdata_next = sum_view;
			end else if (addr == `CRC_STAT_OFS) begin
				rdata_next = {30'h0000_0000, ovf_reg,
					active || buf_out_valid};
			end else begin
				rdata_next = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;
	assign dma_ready = buf_in_ready;

	// checks on polynomials from a zero accumulator and a single one bit
	a_poly_8005: assert property (@(posedge clk) disable iff (sys_rst)
		active && !seed_wr && poly_sel == POLY_CRC16 && crc_reg == 32'h0
		&& step_byte == 8'h01 |=> crc_reg == `CRC_POLY_8005)
		else $error("crc16 step wrong");
	a_poly_1021: assert property (@(posedge clk) disable iff (sys_rst)
		active && !seed_wr && poly_sel == POLY_CCITT && crc_reg == 32'h0
		&& step_byte == 8'h01 |=> crc_reg == `CRC_POLY_1021)
		else $error("ccitt step wrong");
	a_poly_32: assert property (@(posedge clk) disable iff (sys_rst)
		active && !seed_wr && poly_sel == POLY_CRC32 && crc_reg == 32'h0
		&& step_byte == 8'h01 |=> crc_reg == `CRC_POLY_32)
		else $error("crc32 step wrong");

	// checks on sum transforms
	a_sum_cmpl: assert property (@(posedge clk) disable iff (sys_rst)
		rd && addr == `CRC_SUM_OFS && poly_sel == POLY_CRC32
		&& ctrl_reg[7:5] == 3'h1 |=> rdata == ~$past(crc_reg))
		else $error("sum complement wrong");
	a_sum_width: assert property (@(posedge clk) disable iff (sys_rst)
		rd && addr == `CRC_SUM_OFS && poly_sel != POLY_CRC32
		&& ctrl_reg[7:5] == 3'h0
		|=> rdata == {16'h0000, $past(crc_reg[15:0])})
		else $error("sum width wrong");

	// update timing by width
	sequence s_word_run;
		(state_reg == ST_RUN)[*3] ##1 (state_reg == ST_IDLE);
	endsequence
	sequence s_half_run;
		(state_reg == ST_RUN) ##1 (state_reg == ST_IDLE);
	endsequence
	a_byte_one: assert property (@(posedge clk) disable iff (sys_rst)
		take && buf_out_data[33:32] == SZ_BYTE
		|=> state_reg == ST_IDLE && remain_reg == 2'h0)
		else $error("byte took more than one cycle");
	a_word_four: assert property (@(posedge clk) disable iff (sys_rst)
		take && buf_out_data[33:32] == SZ_WORD |=> s_word_run)
		else $error("word not done in four cycles");
	a_half_two: assert property (@(posedge clk) disable iff (sys_rst)
		take && buf_out_data[33:32] == SZ_HALF |=> s_half_run)
		else $error("half-word not done in two cycles");

	// accumulator load and hold
	a_seed_load: assert property (@(posedge clk) disable iff (sys_rst)
		seed_wr |=> crc_reg == $past(wdata))
		else $error("seed not loaded");
	a_crc_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!active && !seed_wr |=> crc_reg == $past(crc_reg))
		else $error("accumulator moved while idle");

	// dma priority over a colliding register write, and read data zero outside its cycle
	a_dma_collide: assert property (@(posedge clk) disable iff (sys_rst)
		dma_valid && dma_ready && reg_data_wr |=> ovf_reg)
		else $error("collision not flagged");
	a_rdata_once: assert property (@(posedge clk) disable iff (sys_rst)
		!rd |=> rdata == 32'h0000_0000)
		else $error("read data outside its cycle");

	// raw 32-bit result and busy flag as read back
	a_sum_select: assert property (@(posedge clk) disable iff (sys_rst)
		rd && addr == `CRC_SUM_OFS && poly_sel == POLY_CRC32
		&& ctrl_reg[7:5] == 3'h0 |=> rdata == $past(crc_reg))
		else $error("32-bit sum wrong");
	a_busy_status: assert property (@(posedge clk) disable iff (sys_rst)
		rd && addr == `CRC_STAT_OFS && active |=> rdata[0])
		else $error("busy not shown while stepping");
endmodule
`default_nettype wire

// ==== sim/dma_source.sv ====
// dma controller model that feeds words into the crc unit data port
`default_nettype none
module dma_source (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic dma_ready,
	output var logic dma_valid,
	output var logic [31:0] dma_data,
	output var crc_pkg::size_t dma_size
);
	timeunit 1ns;
	timeprecision 1ps;
	import crc_pkg::*;

	logic [33:0] q[$];
	logic [33:0] head;
	logic gap_reg;

	// queue filled by the bench, one entry per transfer
	task automatic push(input logic [31:0] d, input size_t s);
		q.push_back({s, d});
	endtask

	// offer one entry, hold it until taken; slow mode idles every other slot
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dma_valid <= 1'b0;
			dma_data <= 32'h0;
			dma_size <= SZ_WORD;
			gap_reg <= 1'b0;
		end else if (!dma_valid || dma_ready) begin
			gap_reg <= ~gap_reg;
			if (q.size() != 0 && !(slow && gap_reg)) begin
				head = q.pop_front();
				dma_size <= size_t'(head[33:32]);
				dma_data <= head[31:0];
				dma_valid <= 1'b1;
			end else begin
				dma_valid <= 1'b0;
				dma_data <= ~dma_data; // released bus keeps moving
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb_crc16_crc32_calculation_unit.sv ====
// self-checking bench for the crc unit
`default_nettype none
`include "crc_params.svh"
module tb_crc16_crc32_calculation_unit;
	timeunit 1ns;
	timeprecision 1ps;
	import crc_pkg::*;

	typedef struct packed {
		logic [7:0] ctrl;
		logic reseed;
		logic [31:0] seed;
		logic [7:0] ofs;
		logic [31:0] data;
	} row_t;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slow = 1'b0;
	logic saw_stall = 1'b0;
	logic [31:0] rdata, dma_data, got, acc;
	logic dma_valid, dma_ready;
	size_t dma_size;
	int err_total = 0;
	int cmp_count = 0;
	int n;
	row_t rows [14] = '{
		'{8'h00, 1'b1, 32'h0000FFFF, `CRC_DATA8_OFS, 32'h31},
		'{8'h00, 1'b0, 32'h0, `CRC_DATA16_OFS, 32'h3233},
		'{8'h01, 1'b1, 32'h0000FFFF, `CRC_DATA32_OFS, 32'h31323334},
		'{8'h02, 1'b1, 32'hFFFFFFFF, `CRC_DATA32_OFS, 32'h31323334},
		'{8'h02, 1'b0, 32'h0, `CRC_DATA8_OFS, 32'hA5},
		'{8'h96, 1'b1, 32'hFFFFFFFF, `CRC_DATA32_OFS, 32'h12345678},
		'{8'h69, 1'b1, 32'h00001D0F, `CRC_DATA32_OFS, 32'h89ABCDEF},
		'{8'h03, 1'b1, 32'h00000000, `CRC_DATA16_OFS, 32'hC0DE},
		'{8'h6A, 1'b1, 32'h5A5A5A5A, `CRC_DATA32_OFS, 32'h0F1E2D3C},
		'{8'h94, 1'b1, 32'h0000ABCD, `CRC_DATA8_OFS, 32'h7E},
		'{8'h00, 1'b1, 32'h00000000, `CRC_DATA8_OFS, 32'h01},
		'{8'h01, 1'b1, 32'h00000000, `CRC_DATA8_OFS, 32'h01},
		'{8'h22, 1'b1, 32'hFFFFFFFF, `CRC_DATA32_OFS, 32'h31323334},
		'{8'h09, 1'b1, 32'h0000BEEF, `CRC_DATA16_OFS, 32'hA55A}};
	logic [31:0] dd [5] = '{32'h01020304, 32'h55, 32'hBEEF, 32'hCAFEF00D,
		32'h0BADF00D};
	size_t dz [5] = '{SZ_WORD, SZ_BYTE, SZ_HALF, SZ_WORD, SZ_WORD};

	always #4 clk = ~clk;

	crc_unit dut (.clk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata,
		.dma_valid, .dma_data, .dma_size, .dma_ready);
	dma_source src (.clk, .sys_rst, .slow, .dma_ready, .dma_valid,
		.dma_data, .dma_size);

	// notes that the data port pushed back at least once
	always @(posedge clk) begin
		if (!sys_rst && !dma_ready) saw_stall <= 1'b1;
	end

	// msb-first crc over n low bytes after the data transforms
	function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] d,
			int n, logic [7:0] ct);
		logic [31:0] p;
		logic w;
		logic fb;
		logic [7:0] b;
		w = (ct[1:0] == 2'h2);
		p = w ? 32'h04C11DB7 : (ct[1:0] == 2'h1) ? 32'h1021 : 32'h8005;
		if (ct[2]) d = ~d;
		for (int i = 0; i < n; i++) begin
			// byte reverse acts within the written width only
			b = d[8*(ct[3] ? n-1-i : i) +: 8];
			if (ct[4]) b = {<<{b}};
			for (int k = 7; k >= 0; k--) begin
				fb = (w ? c[31] : c[15]) ^ b[k];
				c = (c << 1) ^ (fb ? p : 32'h0);
			end
		end
		return c;
	endfunction

	// result as read back, after the sum transforms
	function automatic logic [31:0] sumx(logic [31:0] c, logic [7:0] ct);
		logic w;
		w = (ct[1:0] == 2'h2);
		if (!w) c[31:16] = 16'h0;
		if (ct[5]) c = w ? ~c : {16'h0, ~c[15:0]};
		if (ct[6]) c = w ? {c[7:0], c[15:8], c[23:16], c[31:24]} :
			{16'h0, c[7:0], c[15:8]};
		if (ct[7]) for (int i = 0; i < 4; i++) c[8*i +: 8] = {<<{c[8*i +: 8]}};
		return c;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_total++;
			$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wait_idle();
		logic [31:0] s;
		s = 32'h1;
		for (int i = 0; i < 50 && s[0] !== 1'b0; i++) rd_reg(`CRC_STAT_OFS, s);
		check({31'h0, s[0]}, 32'h0);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("ERROR t=%0t watchdog expired", $time);
		close_out();
	end

	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values, unmapped place included
		foreach (dd[i]) begin
			rd_reg(8'(4 * i + 4 * (i / 4)), got);
			check(got, 32'h0);
		end
		check({31'h0, dma_ready}, 32'h1);
		$display("test reset done");
		// table of polynomials, transforms and widths
		foreach (rows[i]) begin
			wr_reg(`CRC_CTRL_OFS, {24'h0, rows[i].ctrl});
			if (rows[i].reseed) begin
				wr_reg(`CRC_SEED_OFS, rows[i].seed);
				acc = rows[i].seed;
			end
			n = (rows[i].ofs == `CRC_DATA8_OFS) ? 1 :
				(rows[i].ofs == `CRC_DATA16_OFS) ? 2 : 4;
			wr_reg(rows[i].ofs, rows[i].data);
			acc = fold(acc, rows[i].data, n, rows[i].ctrl);
			wait_idle();
			rd_reg(`CRC_SUM_OFS, got);
			check(got, sumx(acc, rows[i].ctrl));
			if (rows[i].ctrl[1:0] == 2'h2) begin
				rd_reg(`CRC_SEED_OFS, got);
				check(got, acc);
			end
		end
		$display("test table done");
		// busy length per width, status read every cycle
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			addr <= (k == 0) ? `CRC_DATA8_OFS :
				(k == 1) ? `CRC_DATA16_OFS : `CRC_DATA32_OFS;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			addr <= `CRC_STAT_OFS;
			rd <= 1'b1;
			n = 0;
			repeat (8) begin
				@(posedge clk);
				#1 n += int'(rdata[0]);
			end
			@(posedge clk);
			rd <= 1'b0;
			check(32'(n), 32'(1 << k));
		end
		$display("test timing done");
		// dma stream, prompt and slow
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			wr_reg(`CRC_CTRL_OFS, 32'h2);
			wr_reg(`CRC_SEED_OFS, 32'hFFFFFFFF);
			acc = 32'hFFFFFFFF;
			#1;
			foreach (dd[j]) begin
				src.push(dd[j], dz[j]);
				acc = fold(acc, dd[j], int'(dz[j]) + 1, 8'h02);
			end
			for (int t = 0; t < 200 && (src.q.size() != 0 || dma_valid); t++)
			begin
				@(posedge clk);
				#1;
			end
			wait_idle();
			rd_reg(`CRC_SUM_OFS, got);
			check(got, acc);
		end
		check({31'h0, saw_stall}, 32'h1);
		$display("test dma done");
		// register data write beside a dma handshake is dropped
		slow <= 1'b0;
		wr_reg(`CRC_SEED_OFS, 32'h0);
		#1 src.push(32'h01, SZ_BYTE);
		@(posedge clk);
		addr <= `CRC_DATA8_OFS;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wait_idle();
		rd_reg(`CRC_SUM_OFS, got);
		check(got, `CRC_POLY_32);
		rd_reg(`CRC_STAT_OFS, got);
		check(got, 32'h2);
		wr_reg(`CRC_STAT_OFS, 32'h2);
		$display("test collide done");
		// back-to-back data writes overrun the buffer
		@(posedge clk);
		addr <= `CRC_DATA32_OFS;
		wr <= 1'b1;
		repeat (6) @(posedge clk);
		wr <= 1'b0;
		wait_idle();
		rd_reg(`CRC_STAT_OFS, got);
		check(got & 32'h2, 32'h2);
		wr_reg(`CRC_STAT_OFS, 32'h2);
		rd_reg(`CRC_STAT_OFS, got);
		check(got, 32'h0);
		$display("test overflow done");
		// reset in mid computation
		wr_reg(`CRC_SEED_OFS, 32'h12345678);
		wr_reg(`CRC_DATA32_OFS, 32'h1);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd_reg(`CRC_SEED_OFS, got);
		check(got, 32'h0);
		rd_reg(`CRC_CTRL_OFS, got);
		check(got, 32'h0);
		$display("test mid reset done");
		close_out();
	end
endmodule
`default_nettype wire
